// >>> hw/cwp_defs.vh
// Constants for the code and write protection gate.
// Assumes inclusion by bare name from the design files.
`ifndef CWP_DEFS_VH
`define CWP_DEFS_VH
// ==========================================================
// Register offsets
`define CWP_OFS_CFG2      4'h0
`define CWP_OFS_CFG1      4'h1
`define CWP_OFS_STATUS    4'h2
`define CWP_OFS_VIOL      4'h3
// ==========================================================
// Field positions
`define CWP_SWG_LO        0
`define CWP_SWG_HI        1
`define CWP_RSV_BIT       4
`define CWP_PLOCK_BIT     0
`define CWP_ELOCK_BIT     1
// ==========================================================
// Reset and erased values
`define CWP_CFG2_ERASED   14'h3FFF
`define CWP_CFG1_ERASED   2'h3
// ==========================================================
// Self-write guard limits (first writable address)
`define CWP_LIM_OFF       12'h000
`define CWP_LIM_10        12'h200
`define CWP_LIM_01        12'h800
`define CWP_LIM_ALL       13'h1000
// ==========================================================
// Timing counts
`define CWP_SETTLE_LAST   2'h2
`endif

// >>> hw/cwp_gate.v
// Protection gate between memories, the CPU and an external programmer.
// Assumes configuration words arrive as pins; the register port is on mclk.
//
// Overview of operation
// - Guard field is configuration word bits 1-0
// - Guard 11 off, 10/01/00 protect low ranges
// - Program lock low: refuse writes, read zero
// - CPU always reads program memory
// - EEPROM lock low blocks external access
// - CPU always reads and writes EEPROM
// - One independent lock bit per memory
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "cwp_defs.vh"
module cwp_gate
(
  input  wire        mclk,
  input  wire        rst_n,
  // Configuration pins
  input  wire [13:0] cfg2_word,
  input  wire        program_lock_n,
  input  wire        eeprom_lock_n,
  // External programmer, program memory
  input  wire        ext_pm_wr,
  input  wire        ext_pm_rd,
  input  wire [12:0] ext_pm_addr,
  input  wire [13:0] ext_pm_wdata,
  output reg  [13:0] ext_pm_rdata,
  output reg         ext_pm_rvalid,
  // External programmer, data EEPROM
  input  wire        ext_ee_wr,
  input  wire        ext_ee_rd,
  input  wire [7:0]  ext_ee_addr,
  input  wire [7:0]  ext_ee_wdata,
  output reg  [7:0]  ext_ee_rdata,
  output reg         ext_ee_rvalid,
  // CPU, program memory
  input  wire        cpu_pm_rd,
  input  wire        cpu_pm_wr,
  input  wire [12:0] cpu_pm_addr,
  input  wire [13:0] cpu_pm_wdata,
  output reg  [13:0] cpu_pm_rdata,
  output reg         cpu_pm_wblocked,
  // CPU, data EEPROM
  input  wire        cpu_ee_rd,
  input  wire        cpu_ee_wr,
  input  wire [7:0]  cpu_ee_addr,
  input  wire [7:0]  cpu_ee_wdata,
  output reg  [7:0]  cpu_ee_rdata,
  // Program memory port
  output reg         pm_rd,
  output reg         pm_wr,
  output reg  [12:0] pm_addr,
  output reg  [13:0] pm_wdata,
  input  wire [13:0] pm_rdata,
  // EEPROM port
  output reg         ee_rd,
  output reg         ee_wr,
  output reg  [7:0]  ee_addr,
  output reg  [7:0]  ee_wdata,
  input  wire [7:0]  ee_rdata,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata
);
  // ==========================================================
  // Pin synchronisers
  wire [15:0] cfg_sync;
  cwp_sync2 #(.W(16)) u_sync
  (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({eeprom_lock_n, program_lock_n, cfg2_word}),
    .q     (cfg_sync)
  );

  // ==========================================================
  // Capture at reset release
  reg        captured;
  reg [1:0]  settle;
  reg [13:0] cfg2;
  reg        plock_n;
  reg        elock_n;
  // capture once, hold
  // The synchroniser needs two edges to fill; capturing any earlier would
  // latch its reset zeros and lock both memories by mistake
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settle   <= 2'h0;
      captured <= 1'b0;
      cfg2     <= `CWP_CFG2_ERASED;
      plock_n  <= 1'b0;              // Locked until captured
      elock_n  <= 1'b0;
    end
    else if (!captured)
    begin
      settle <= settle + 2'h1;
      if (settle == `CWP_SETTLE_LAST)
      begin
        captured <= 1'b1;
        cfg2     <= cfg_sync[13:0];
        plock_n  <= cfg_sync[14];
        elock_n  <= cfg_sync[15];
      end
    end
  end

  wire [1:0] self_write_guard = cfg2[`CWP_SWG_HI:`CWP_SWG_LO];

  // ==========================================================
  // Self-write range check
  wire swg_blocked;
  cwp_swg_decode u_swg
  (
    .guard   (self_write_guard),
    .addr    (cpu_pm_addr),
    .blocked (swg_blocked)
  );

  // ==========================================================
  // Arbitration and gating
  // CPU has priority; external access is dropped in a CPU cycle.
  // A dropped external read gets no rvalid, so the tool must retry it.
  reg         next_pm_rd;
  reg         next_pm_wr;
  reg  [12:0] next_pm_addr;
  reg  [13:0] next_pm_wdata;
  reg         next_ee_rd;
  reg         next_ee_wr;
  reg  [7:0]  next_ee_addr;
  reg  [7:0]  next_ee_wdata;
  wire        cpu_pm = cpu_pm_rd | cpu_pm_wr;
  wire        cpu_ee = cpu_ee_rd | cpu_ee_wr;
  always @*
  begin
    next_pm_rd    = 1'b0;
    next_pm_wr    = 1'b0;
    next_pm_addr  = ext_pm_addr;
    next_pm_wdata = ext_pm_wdata;
    next_ee_rd    = 1'b0;
    next_ee_wr    = 1'b0;
    next_ee_addr  = ext_ee_addr;
    next_ee_wdata = ext_ee_wdata;
    if (cpu_pm)
    begin
      next_pm_addr  = cpu_pm_addr;
      next_pm_wdata = cpu_pm_wdata;
      next_pm_rd    = cpu_pm_rd;
      next_pm_wr    = cpu_pm_wr & ~swg_blocked & captured;
    end
    else
    begin
      next_pm_rd = ext_pm_rd & plock_n;
      next_pm_wr = ext_pm_wr & plock_n;
    end
    if (cpu_ee)
    begin
      next_ee_addr  = cpu_ee_addr;
      next_ee_wdata = cpu_ee_wdata;
      next_ee_rd    = cpu_ee_rd;
      next_ee_wr    = cpu_ee_wr;
    end
    else
    begin
      next_ee_rd = ext_ee_rd & elock_n;
      next_ee_wr = ext_ee_wr & elock_n;
    end
  end

  // ==========================================================
  // Memory strobes and read return tracking
  // The lock travels with the read, so the answer follows the lock at request time
  reg pm_ext_rd_q;   // External program read in flight
  reg pm_ext_zero_q; // That read answers zero
  reg ee_ext_rd_q;
  reg pm_cpu_rd_q;
  reg ee_cpu_rd_q;
  reg pm_viol_q;
  reg ee_viol_q;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pm_rd         <= 1'b0;
      pm_wr         <= 1'b0;
      pm_addr       <= 13'h0000;
      pm_wdata      <= 14'h0000;
      ee_rd         <= 1'b0;
      ee_wr         <= 1'b0;
      ee_addr       <= 8'h00;
      ee_wdata      <= 8'h00;
      pm_ext_rd_q   <= 1'b0;
      pm_ext_zero_q <= 1'b0;
      ee_ext_rd_q   <= 1'b0;
      pm_cpu_rd_q   <= 1'b0;
      ee_cpu_rd_q   <= 1'b0;
      cpu_pm_wblocked <= 1'b0;
    end
    else
    begin
      pm_rd         <= next_pm_rd;
      pm_wr         <= next_pm_wr;
      pm_addr       <= next_pm_addr;
      pm_wdata      <= next_pm_wdata;
      ee_rd         <= next_ee_rd;
      ee_wr         <= next_ee_wr;
      ee_addr       <= next_ee_addr;
      ee_wdata      <= next_ee_wdata;
      pm_ext_rd_q   <= ext_pm_rd & ~cpu_pm;
      pm_ext_zero_q <= ~plock_n;
      ee_ext_rd_q   <= ext_ee_rd & ~cpu_ee & elock_n;
      pm_cpu_rd_q   <= cpu_pm_rd;
      ee_cpu_rd_q   <= cpu_ee_rd;
      cpu_pm_wblocked <= cpu_pm_wr & (swg_blocked | ~captured);
    end
  end

  // ==========================================================
  // Read data return, one cycle after the memory strobe
  // The memories answer within the strobe cycle; the word is taken at the edge
  // that ends it, so no extra stage sits between memory and requester.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_pm_rdata  <= 14'h0000;
      ext_pm_rvalid <= 1'b0;
      ext_ee_rdata  <= 8'h00;
      ext_ee_rvalid <= 1'b0;
      cpu_pm_rdata  <= 14'h0000;
      cpu_ee_rdata  <= 8'h00;
    end
    else
    begin
      ext_pm_rvalid <= pm_ext_rd_q;
      ext_pm_rdata  <= (pm_ext_rd_q & ~pm_ext_zero_q) ? pm_rdata : 14'h0000;
      ext_ee_rvalid <= ee_ext_rd_q;
      ext_ee_rdata  <= ee_ext_rd_q ? ee_rdata : 8'h00;
      if (pm_cpu_rd_q)
        cpu_pm_rdata <= pm_rdata;
      if (ee_cpu_rd_q)
        cpu_ee_rdata <= ee_rdata;
    end
  end

  // ==========================================================
  // Violation flags: set by refused external access, cleared by
  // writing one; a set in the clear cycle wins.
  // They are diagnostic only and never gate an access.
  wire pm_viol_set = ~cpu_pm & ~plock_n & (ext_pm_rd | ext_pm_wr);
  wire ee_viol_set = ~cpu_ee & ~elock_n & (ext_ee_rd | ext_ee_wr);
  wire viol_clr    = reg_wr & (reg_addr == `CWP_OFS_VIOL);
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pm_viol_q <= 1'b0;
      ee_viol_q <= 1'b0;
    end
    else
    begin
      pm_viol_q <= pm_viol_set | (pm_viol_q & ~(viol_clr & reg_wdata[0]));
      ee_viol_q <= ee_viol_set | (ee_viol_q & ~(viol_clr & reg_wdata[1]));
    end
  end

  // ==========================================================
  // Register read port; captured settings are read only
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `CWP_OFS_CFG2:   reg_rdata <= {2'h0, cfg2};
        `CWP_OFS_CFG1:   reg_rdata <= {14'h0000, elock_n, plock_n};
        `CWP_OFS_STATUS: reg_rdata <= {13'h0000, captured, self_write_guard};
        `CWP_OFS_VIOL:   reg_rdata <= {14'h0000, ee_viol_q, pm_viol_q};
        default:         reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end
endmodule // cwp_gate
`default_nettype wire

// >>> hw/cwp_swg_decode.v
// Self-write guard decode for the flash write control path.
// Assumes a settled guard field and a 13-bit program address.
`timescale 1ns/10ps
`default_nettype none
`include "cwp_defs.vh"
module cwp_swg_decode
(
  input  wire [1:0]  guard,
  input  wire [12:0] addr,
  output reg         blocked
);
  reg [12:0] limit;
  // ==========================================================
  // Decode
  // guard range decode
  always @*
  begin
    case (guard)
      2'h3:    limit = {1'b0, `CWP_LIM_OFF};
      2'h2:    limit = {1'b0, `CWP_LIM_10};
      2'h1:    limit = {1'b0, `CWP_LIM_01};
      default: limit = `CWP_LIM_ALL;
    endcase
    blocked = (addr < limit);
  end
endmodule // cwp_swg_decode
`default_nettype wire

// >>> hw/cwp_sync2.v
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
module cwp_sync2 #(
  parameter W = 4
)
(
  input  wire         mclk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;
  // ==========================================================
  // First flop feeds only the second
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // cwp_sync2
`default_nettype wire

// >>> tb/cwp_gate_sva.sv
// Protocol checker for the protection gate.
// Assumes pins stay put until three edges after reset release.
`timescale 1ns/10ps
`default_nettype none
module cwp_gate_sva
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [13:0] cfg2_word,
  input wire logic        program_lock_n,
  input wire logic        eeprom_lock_n,
  input wire logic        ext_pm_rd,
  input wire logic        ext_pm_rvalid,
  input wire logic [13:0] ext_pm_rdata,
  input wire logic        ext_ee_rd,
  input wire logic        ext_ee_wr,
  input wire logic        ext_ee_rvalid,
  input wire logic        cpu_pm_rd,
  input wire logic        cpu_pm_wr,
  input wire logic [12:0] cpu_pm_addr,
  input wire logic        cpu_pm_wblocked,
  input wire logic        cpu_ee_rd,
  input wire logic        cpu_ee_wr,
  input wire logic        pm_rd,
  input wire logic        pm_wr,
  input wire logic [12:0] pm_addr,
  input wire logic        ee_rd,
  input wire logic        ee_wr,
  input wire logic        reg_rd,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_rdata
);
  logic [1:0] c, g;
  logic       pl, el;
  wire        ok = (c == 2'h3);
  function automatic logic blk(input logic [1:0] gg, input logic [12:0] ad);
    blk = (gg == 2'h3) ? 1'b0 : (gg == 2'h2) ? (ad < 13'h200) : (gg == 2'h1) ? (ad < 13'h800) : (ad < 13'h1000);
  endfunction
  // ==========================================================
  // Own copy of the captured settings, taken at the third edge
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      c <= 2'h0;
    else if (c != 2'h3)
    begin
      c <= c + 2'h1;
      if (c == 2'h2)
        {pl, el, g} <= {program_lock_n, eeprom_lock_n, cfg2_word[1:0]};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Assertions
  pm_lock_a: assert property (ok && !pl && ext_pm_rd && !cpu_pm_rd && !cpu_pm_wr
    |=> !pm_rd ##1 ext_pm_rvalid && ext_pm_rdata == 14'h0000) else $error("locked flash read leaked");
  ee_lock_a: assert property (ok && !el && (ext_ee_rd || ext_ee_wr) && !cpu_ee_rd && !cpu_ee_wr
    |=> !ee_rd && !ee_wr ##1 !ext_ee_rvalid) else $error("locked eeprom access leaked");
  cpu_read_a: assert property (ok && cpu_pm_rd |=> pm_rd && pm_addr == $past(cpu_pm_addr))
    else $error("cpu flash read lost");
  cpu_ee_a: assert property (ok && (cpu_ee_rd || cpu_ee_wr)
    |=> ee_rd == $past(cpu_ee_rd) && ee_wr == $past(cpu_ee_wr)) else $error("cpu eeprom access lost");
  guard_range_a: assert property (ok && cpu_pm_wr
    |=> pm_wr != blk(g, $past(cpu_pm_addr)) && cpu_pm_wblocked == blk(g, $past(cpu_pm_addr)))
    else $error("self write guard wrong");
  pm_open_a: assert property (ok && pl && ext_pm_rd && !cpu_pm_rd && !cpu_pm_wr
    |=> pm_rd ##1 ext_pm_rvalid) else $error("open flash read refused");
  lock_hold_a: assert property (ok && reg_rd && reg_addr == 4'h1 |=> reg_rdata[1:0] == {el, pl})
    else $error("captured locks changed");
  guard_field_a: assert property (ok && reg_rd && reg_addr == 4'h2 |=> reg_rdata[2:0] == {1'b1, g})
    else $error("guard field wrong");
  cover property (ok && !pl && ext_pm_rd);
  cover property (ok && cpu_pm_wblocked);
  cover property (ok && ext_ee_rvalid);
endmodule // cwp_gate_sva
bind cwp_gate cwp_gate_sva u_sva (.*);
`default_nettype wire

// >>> tb/cwp_gate_tb.sv
// Self-checking bench for the protection gate.
// Assumes the memory model answers reads; runs four lock and guard phases.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module cwp_gate_tb;
  logic        mclk = 1'b0, rst_n, program_lock_n, eeprom_lock_n, ext_pm_wr, ext_pm_rd, ext_ee_wr, ext_ee_rd;
  logic        cpu_pm_rd, cpu_pm_wr, cpu_ee_rd, cpu_ee_wr, reg_wr, reg_rd, ext_pm_rvalid, ext_ee_rvalid;
  logic        cpu_pm_wblocked, pm_rd, pm_wr, ee_rd, ee_wr, r1, pl, el;
  logic [12:0] ext_pm_addr, cpu_pm_addr, pm_addr, a;
  logic [13:0] cfg2_word, ext_pm_wdata, ext_pm_rdata, cpu_pm_wdata, cpu_pm_rdata, pm_wdata, pm_rdata, d;
  logic [7:0]  ext_ee_addr, ext_ee_wdata, ext_ee_rdata, cpu_ee_addr, cpu_ee_wdata, cpu_ee_rdata;
  logic [7:0]  ee_addr, ee_wdata, ee_rdata;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [9:0]  st = 10'h000;
  logic [3:0]  cp = 4'h0;
  logic [17:0] q[$];
  logic [13:0] rx[4];
  int          seed = 47587, n_errors = 0, check_count = 0, k, i, j;
  int          lim[6] = '{'h1FF, 'h200, 'h7FF, 'h800, 'hFFF, 'h1000};
  int          gl[4] = '{'h1000, 'h800, 'h200, 0};
  assign {reg_wr, reg_rd, cpu_ee_wr, cpu_ee_rd, cpu_pm_wr, cpu_pm_rd, ext_ee_wr, ext_ee_rd, ext_pm_wr, ext_pm_rd} = st;
  cwp_gate dut (.*);
  cwp_mem_model u_mem (.*);
  always #5 mclk = ~mclk;
  // ==========================================================
  // Driver tasks: one strobe, then a gap for both answer cycles
  task automatic go(input int s);
    st <= 10'h001 << s;
    @(posedge mclk);
    st <= 10'h000;
    repeat (4) @(posedge mclk);
  endtask
  task automatic ex(input logic [3:0] t, input logic [13:0] v);
    q.push_back({t, v});
  endtask
  task automatic take(input logic [17:0] v);
    logic [17:0] e;
    e = (q.size() != 0) ? q.pop_front() : 18'h3FFFF;
    `CHK(v, e)
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // Monitor: settled outputs at the falling edge, oldest note first
  always @(negedge mclk)
  begin
    if (ext_pm_rvalid === 1'b1) take({4'h1, ext_pm_rdata});
    if (ext_ee_rvalid === 1'b1) take({4'h2, 6'h00, ext_ee_rdata});
    if (pm_wr === 1'b1) take({4'h3, pm_wdata});
    if (pm_rd === 1'b1) take({4'h4, 1'b0, pm_addr});
    if (ee_rd === 1'b1) take({4'h5, 6'h00, ee_addr});
    if (r1 === 1'b1) take({4'h6, reg_rdata[13:0]});
    if (ee_wr === 1'b1) take({4'h7, 6'h00, ee_wdata});
    if (cpu_pm_wblocked === 1'b1) take({4'h8, 14'h0000});
    if (cp[2] === 1'b1) take({4'h9, cpu_pm_rdata});
    if (cp[3] === 1'b1) take({4'hA, 6'h00, cpu_ee_rdata});
    r1 = reg_rd;
    cp = {cp[1:0], cpu_ee_rd, cpu_pm_rd};
  end
  initial
  begin
    #100000;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    {rst_n, program_lock_n, eeprom_lock_n, r1} = 4'h0;
    {ext_pm_addr, cpu_pm_addr, ext_pm_wdata, cpu_pm_wdata, ext_ee_addr, ext_ee_wdata} = '0;
    {cpu_ee_addr, cpu_ee_wdata, reg_addr, reg_wdata, cfg2_word} = '0;
    for (k = 0; k < 4; k++)
    begin
      // Every lock pair and guard code, one phase each
      pl = k[0];
      el = k[1];
      rst_n <= 1'b0;
      program_lock_n <= pl;
      eeprom_lock_n <= el;
      // reserved bit four programmed to one
      cfg2_word <= {12'hFFF, k[1:0]};
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      // Pins flip after capture; nothing may follow them
      program_lock_n <= !pl;
      eeprom_lock_n <= !el;
      cfg2_word[1:0] <= ~k[1:0];
      reg_wdata <= 16'($random(seed));
      reg_addr <= 4'hA;
      go(9);
      rx = '{{12'hFFF, k[1:0]}, {12'h000, el, pl}, {11'h000, 1'b1, k[1:0]}, 14'h0000};
      for (i = 0; i < 4; i++)
      begin
        reg_addr <= (i == 3) ? 4'hA : 4'(i);
        ex(6, rx[i]);
        go(8);
      end
      for (i = 0; i < 6; i++)
      begin
        a = 13'($random(seed));
        d = 14'($random(seed));
        {ext_pm_addr, cpu_pm_addr, ext_pm_wdata} <= {a, a, d};
        {ext_ee_addr, cpu_ee_addr, ext_ee_wdata, cpu_ee_wdata} <= {a[7:0], a[7:0], d[7:0], d[7:0]};
        if (pl) ex(4, {1'b0, a});
        ex(1, pl ? ({1'b1, a} ^ 14'h2A5A) : 14'h0000);
        go(0);
        if (pl) ex(3, d);
        go(1);
        if (el) ex(5, {6'h00, a[7:0]});
        if (el) ex(2, {6'h00, a[7:0] ^ 8'hC3});
        go(2);
        if (el) ex(7, {6'h00, d[7:0]});
        go(3);
        ex(4, {1'b0, a});
        ex(9, {1'b1, a} ^ 14'h2A5A);
        go(4);
        ex(5, {6'h00, a[7:0]});
        ex(10, {6'h00, a[7:0] ^ 8'hC3});
        go(6);
        ex(7, {6'h00, d[7:0]});
        go(7);
      end
      // Refused external accesses leave their flags; writing ones clears them
      reg_addr <= 4'h3;
      ex(6, {12'h000, !el, !pl});
      go(8);
      reg_wdata <= 16'h0003;
      go(9);
      ex(6, 14'h0000);
      go(8);
      for (j = 0; j < 6; j++)
      begin
        cpu_pm_addr <= 13'(lim[j]);
        cpu_pm_wdata <= d;
        ex((lim[j] < gl[k]) ? 4'h8 : 4'h3, (lim[j] < gl[k]) ? 14'h0000 : d);
        go(5);
      end
    end
    `CHK(q.size(), 0)
    report_and_stop();
  end
endmodule // cwp_gate_tb
`default_nettype wire

// >>> tb/cwp_mem_model.sv
// Memory behind the gate: program flash and data EEPROM.
// Assumes the gate takes read data at the edge that ends the strobe cycle.
`timescale 1ns/10ps
`default_nettype none
module cwp_mem_model
(
  input  wire logic        mclk,
  input  wire logic        pm_rd,
  input  wire logic [12:0] pm_addr,
  output var  logic [13:0] pm_rdata,
  input  wire logic        ee_rd,
  input  wire logic [7:0]  ee_addr,
  output var  logic [7:0]  ee_rdata
);
  logic [13:0] pm_idle = 14'h1555;
  logic [7:0]  ee_idle = 8'h55;
  // ==========================================================
  // Idle data toggles so a stale word never matches
  always @(posedge mclk)
  begin
    pm_idle <= ~pm_idle;
    ee_idle <= ~ee_idle;
  end
  // Read answer stands within the strobe cycle itself
  assign pm_rdata = pm_rd ? ({1'b1, pm_addr} ^ 14'h2A5A) : pm_idle;
  assign ee_rdata = ee_rd ? (ee_addr ^ 8'hC3) : ee_idle;
endmodule // cwp_mem_model
`default_nettype wire
